/* shared/ofm_pkg.sv */
// constants and types shared by the frequency measurement and trim block
// Summary of operation
// - count peripheral clocks over window_cycle_select plus one reference periods
// - source select 00b slow osc, 01b crystal (default), 1xb word-select input
// - enable set starts a measurement; clearing it disables and resets measurement
// - done bit reads zero while counting, one once the window has elapsed
// - once done, 16-bit count holds peripheral periods counted in the window
// - superfine is signed; positive dithers one step up, negative one step down
// - each superfine unit moves frequency one 128th of a fine step by dithering
// - trim register bits 15 to 8 read the current coarse setting
// - trim register bits 7 to 0 read the current trim setting
package ofm_pkg;

    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register offsets
    localparam logic [7:0] OFS_TRIM     = 8'h84;
    localparam logic [7:0] OFS_CTRL     = 8'h94;
    localparam logic [7:0] OFS_COUNT    = 8'h98;
    localparam logic [7:0] OFS_IRQ_STAT = 8'hA0;
    localparam logic [7:0] OFS_IRQ_MASK = 8'hA4;

    // control register fields
    localparam int EN_BIT   = 31;
    localparam int CYC_LSB  = 16;
    localparam int CYC_MSB  = 23;
    localparam int DONE_BIT = 2;
    localparam int SEL_LSB  = 0;
    localparam int SEL_MSB  = 1;

    // trim register fields
    localparam int SF_LSB     = 16;
    localparam int SF_MSB     = 23;
    localparam int COARSE_LSB = 8;
    localparam int COARSE_MSB = 15;
    localparam int TRIM_LSB   = 0;
    localparam int TRIM_MSB   = 7;

    // count register field
    localparam int CNT_W = 16;

    // interrupt bits
    localparam int IRQ_W        = 2;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_SAT_BIT  = 1;

    // reset values
    localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [7:0]  SF_RST    = 8'h00;
    localparam logic [1:0]  MASK_RST  = 2'h0;

    // counter and trim limits
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [7:0]  TRIM_MAX  = 8'hFF;
    localparam logic [7:0]  TRIM_MIN  = 8'h00;

    // reference source codes
    localparam logic [1:0] SRC_SLOW = 2'b00;
    localparam logic [1:0] SRC_XTAL = 2'b01;

    // measurement sequence
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARM   = 2'b01,
        ST_COUNT = 2'b10,
        ST_DONE  = 2'b11
    } ofm_state_t;

endpackage

/* design/ofm_ref_sync.sv */
// three-stage synchronisers with rising edge detection for reference inputs
`timescale 1ns/1ns
module ofm_ref_sync #(
    parameter int W = 3
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] rise
);
    logic [W-1:0] meta;
    logic [W-1:0] sync2;
    logic [W-1:0] sync3;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // first stage feeds only the second; edge seen on stages two and three
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    meta[i]  <= 1'b0;
                    sync2[i] <= 1'b0;
                    sync3[i] <= 1'b0;
                end else if (clk_en) begin
                    meta[i]  <= async_in[i];
                    sync2[i] <= meta[i];
                    sync3[i] <= sync2[i];
                end
            end

            // one pulse per reference rise, gated so frozen state gives no edge
            assign rise[i] = clk_en & sync2[i] & ~sync3[i];
        end
    endgenerate
endmodule

/* design/ofm_top.sv */
// peripheral clock frequency measurement against a reference, with trim readback
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
module ofm_top (
    input  wire logic                         ref_clk,
    input  wire logic                         rst,
    input  wire logic                         clk_en,
    input  wire logic [ofm_pkg::ADDR_W-1:0]   addr,
    input  wire logic [ofm_pkg::DATA_W-1:0]   wdata,
    input  wire logic                         wr,
    input  wire logic                         rd,
    input  wire logic                         low_speed_osc,
    input  wire logic                         crystal_osc_ref,
    input  wire logic                         i2s_ws,
    input  wire logic [7:0]                   coarse_in,
    input  wire logic [7:0]                   trim_in,
    output logic      [ofm_pkg::DATA_W-1:0]   rdata,
    output logic      [7:0]                   fine_trim_out,
    output logic                              irq
);
    import ofm_pkg::*;

    // software-visible state
    logic                 measure_enable;
    logic [7:0]           window_cycle_select;
    logic [1:0]           reference_source_select;
    logic [7:0]           superfine;
    logic [IRQ_W-1:0]     irq_status;
    logic [IRQ_W-1:0]     irq_mask;

    // measurement state
    ofm_state_t           state;
    logic [7:0]           edge_cnt;
    logic [CNT_W-1:0]     measured_period_count;
    logic                 measure_done;

    // trim path
    logic [7:0]           coarse_q;
    logic [7:0]           current_trim_value;
    logic [6:0]           dith_acc;
    logic [7:0]           sf_mag;
    logic [7:0]           dith_sum;
    logic [7:0]           next_fine;

    // decode and events
    logic                 wr_ctrl;
    logic                 wr_trim;
    logic                 wr_stat;
    logic                 wr_mask;
    logic [2:0]           ref_rise;
    logic                 ref_edge;
    logic                 done_evt;
    logic                 sat_evt;
    logic [IRQ_W-1:0]     evt;
    logic [IRQ_W-1:0]     next_status;

    // register write decode
    assign wr_ctrl = wr && (addr == OFS_CTRL);
    assign wr_trim = wr && (addr == OFS_TRIM);
    assign wr_stat = wr && (addr == OFS_IRQ_STAT);
    assign wr_mask = wr && (addr == OFS_IRQ_MASK);

    // all reference candidates are synchronised; only the selected one is used
    ofm_ref_sync #(
        .W(3)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .async_in ({i2s_ws, crystal_osc_ref, low_speed_osc}),
        .rise     (ref_rise)
    );

    // reference source mux; both 1x codes pick word-select
    always_comb begin
        if (reference_source_select[1]) begin
            ref_edge = ref_rise[2];
        end else if (reference_source_select == SRC_XTAL) begin
            ref_edge = ref_rise[1];
        end else begin
            ref_edge = ref_rise[0];
        end
    end

    // control register; sequencing is software's job, any order is accepted
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            measure_enable          <= CTRL_RST[EN_BIT];
            window_cycle_select     <= CTRL_RST[CYC_MSB:CYC_LSB];
            reference_source_select <= CTRL_RST[SEL_MSB:SEL_LSB];
        end else if (clk_en && wr_ctrl) begin
            measure_enable          <= wdata[EN_BIT];
            window_cycle_select     <= wdata[CYC_MSB:CYC_LSB];
            reference_source_select <= wdata[SEL_MSB:SEL_LSB];
        end
    end

    // superfine field is the only writable part of the trim register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            superfine <= SF_RST;
        end else if (clk_en && wr_trim) begin
            superfine <= wdata[SF_MSB:SF_LSB];
        end
    end

    // oscillator settings sampled each cycle for readback and dithering
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            coarse_q           <= 8'h00;
            current_trim_value <= 8'h00;
        end else if (clk_en) begin
            coarse_q           <= coarse_in;
            current_trim_value <= trim_in;
        end
    end

    // window end and saturation events
    // saturation flagged one count early so the status bit and the clamped count land together
    assign done_evt = (state == ST_COUNT) && ref_edge && (edge_cnt == window_cycle_select);
    assign sat_evt  = (state == ST_COUNT) && (measured_period_count == COUNT_MAX - 16'h0001);
    assign measure_done = (state == ST_DONE);

    // measurement sequence; first reference edge opens the window
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else if (clk_en) begin
            if (wr_ctrl && !wdata[EN_BIT]) begin
                state <= ST_IDLE;
            end else begin
                unique case (state)
                    ST_IDLE: begin
                        if (measure_enable) begin
                            state <= ST_ARM;
                        end
                    end
                    ST_ARM: begin
                        if (ref_edge) begin
                            state <= ST_COUNT;
                        end
                    end
                    ST_COUNT: begin
                        if (done_evt) begin
                            state <= ST_DONE;
                        end
                    end
                    ST_DONE: begin
                        state <= ST_DONE;
                    end
                endcase
            end
        end
    end

    // reference period counter within the window
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            edge_cnt <= 8'h00;
        end else if (clk_en) begin
            if (state == ST_ARM && ref_edge) begin
                edge_cnt <= 8'h00;
            end else if (state == ST_COUNT && ref_edge) begin
                edge_cnt <= edge_cnt + 8'h01;
            end
        end
    end

    // peripheral clock counter; held from done until the next start
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            measured_period_count <= COUNT_RST;
        end else if (clk_en) begin
            if (state == ST_ARM && ref_edge) begin
                measured_period_count <= COUNT_RST;
            end else if (state == ST_COUNT && measured_period_count != COUNT_MAX) begin
                measured_period_count <= measured_period_count + 16'h0001;
            end
        end
    end

    // superfine dither: a 7-bit phase accumulator, carry picks the next step
    always_comb begin
        sf_mag   = superfine[7] ? (8'h00 - superfine) : superfine;
        dith_sum = {1'b0, dith_acc} + sf_mag;
        if (dith_sum[7] && !superfine[7] && current_trim_value != TRIM_MAX) begin
            next_fine = current_trim_value + 8'h01;
        end else if (dith_sum[7] && superfine[7] && current_trim_value != TRIM_MIN) begin
            next_fine = current_trim_value - 8'h01;
        end else begin
            next_fine = current_trim_value;
        end
    end

    // dither state and fine trim drive; ends of range clamp rather than wrap
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dith_acc      <= 7'h00;
            fine_trim_out <= 8'h00;
        end else if (clk_en) begin
            dith_acc      <= dith_sum[6:0];
            fine_trim_out <= next_fine;
        end
    end

    // sticky status: a new event wins over a same-cycle write-one-to-clear
    assign evt = {sat_evt, done_evt};
    assign next_status = (irq_status & ~(wr_stat ? wdata[IRQ_W-1:0] : 2'h0)) | evt;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_status <= 2'h0;
            irq_mask   <= MASK_RST;
            irq        <= 1'b0;
        end else if (clk_en) begin
            irq_status <= next_status;
            if (wr_mask) begin
                irq_mask <= wdata[IRQ_W-1:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // read port; data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (rd) begin
                unique case (addr)
                    OFS_TRIM:
                        rdata <= {8'h00, superfine, coarse_q, current_trim_value};
                    OFS_CTRL:
                        rdata <= {measure_enable, 7'h00, window_cycle_select, 13'h0000,
                                  measure_done, reference_source_select};
                    OFS_COUNT:
                        rdata <= {16'h0000, measured_period_count};
                    OFS_IRQ_STAT:
                        rdata <= {30'h0000_0000, irq_status};
                    OFS_IRQ_MASK:
                        rdata <= {30'h0000_0000, irq_mask};
                    default:
                        rdata <= 32'h0000_0000;
                endcase
            end else begin
                rdata <= 32'h0000_0000;
            end
        end
    end

    // checks, all on the peripheral clock
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_window_end_done: assert property (
        (clk_en && done_evt && !wr_ctrl) |=> (state == ST_DONE) && measure_done
    ) else $error("window end did not raise done");

    a_source_slow: assert property (
        (clk_en && reference_source_select == SRC_SLOW && state == ST_ARM && !ref_rise[0] && !wr_ctrl)
        |=> state == ST_ARM
    ) else $error("window opened without a slow oscillator edge");

    a_enable_clear: assert property (
        (clk_en && wr_ctrl && !wdata[EN_BIT]) |=> (state == ST_IDLE) && !measure_done
    ) else $error("clearing enable did not reset measurement");

    a_done_ctrl_read: assert property (
        (clk_en && rd && addr == OFS_CTRL) |=> (rdata[DONE_BIT] == $past(measure_done))
    ) else $error("done bit read wrong");

    a_count_held: assert property (
        (state == ST_DONE) |=> $stable(measured_period_count)
    ) else $error("count changed after done");

    a_dither_up: assert property (
        (clk_en && !superfine[7] && current_trim_value != TRIM_MAX)
        |=> (fine_trim_out == $past(current_trim_value))
            || (fine_trim_out == $past(current_trim_value) + 8'h01)
    ) else $error("positive superfine moved trim wrong way");

    a_dither_full_down: assert property (
        (clk_en && superfine == 8'h80 && current_trim_value != TRIM_MIN)
        |=> fine_trim_out == $past(current_trim_value) - 8'h01
    ) else $error("full negative superfine not one step below");

    a_trim_readback: assert property (
        (clk_en && rd && addr == OFS_TRIM)
        |=> rdata[15:0] == {$past(coarse_q), $past(current_trim_value)}
    ) else $error("trim readback mismatch");

    a_count_saturate: assert property (
        (state == ST_COUNT && measured_period_count == COUNT_MAX) |=> measured_period_count == COUNT_MAX
    ) else $error("count wrapped");

    a_irq_level: assert property (
        (clk_en && |(irq_status & irq_mask)) |=> irq
    ) else $error("unmasked status without interrupt");

    // window opening and hold
    a_window_open: assert property (
        (clk_en && state == ST_ARM && ref_edge && !wr_ctrl)
        |=> (state == ST_COUNT) && (edge_cnt == 8'h00) && (measured_period_count == COUNT_RST)
    ) else $error("window did not open on reference edge");

    a_done_hold: assert property (
        (state == ST_DONE && !wr_ctrl) |=> (state == ST_DONE) && measure_done
    ) else $error("done dropped without disable");

    // status, interrupt and read port
    a_done_status: assert property (
        (clk_en && done_evt) |=> irq_status[IRQ_DONE_BIT]
    ) else $error("window end did not set status");

    a_sat_status: assert property (
        (clk_en && sat_evt) |=> irq_status[IRQ_SAT_BIT]
    ) else $error("saturation did not set status");

    a_count_read: assert property (
        (clk_en && rd && addr == OFS_COUNT)
        |=> rdata == {16'h0000, $past(measured_period_count)}
    ) else $error("count readback mismatch");

    a_read_idle: assert property (
        (clk_en && !rd) |=> rdata == 32'h0000_0000
    ) else $error("read data outside a read cycle");

    a_irq_quiet: assert property (
        (clk_en && !(|(irq_status & irq_mask))) |=> !irq
    ) else $error("interrupt without unmasked status");

    // a low clock enable must hold every register
    a_freeze_hold: assert property (
        !clk_en |=> $stable(state) && $stable(measured_period_count) && $stable(fine_trim_out)
    ) else $error("state moved while clock enable low");

    // main scenarios reached
    c_measure_done: cover property (state == ST_COUNT ##1 state == ST_DONE);
    c_saturated: cover property (sat_evt);
    c_ws_source: cover property (reference_source_select[1] && done_evt);
    c_dither_down: cover property (superfine[7] && fine_trim_out != current_trim_value);
    c_dither_up: cover property (!superfine[7] && fine_trim_out != current_trim_value);

endmodule

/* test/ofm_top_tb_top.sv */
// self-checking bench for the frequency measurement and trim block
`timescale 1ns/1ns
module ofm_top_tb_top;
    import ofm_pkg::*;

    logic              ref_clk;
    logic              rst;
    logic              clk_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic              low_speed_osc;
    logic              crystal_osc_ref;
    logic              i2s_ws;
    logic [7:0]        coarse_in;
    logic [7:0]        trim_in;
    logic [DATA_W-1:0] rdata;
    logic [7:0]        fine_trim_out;
    logic              irq;
    int                error_cnt;
    int                n_tests;
    int                ph_s;
    int                ph_x;
    int                ph_w;
    logic [DATA_W-1:0] d;

    // clock enable driven by the bench so the freeze can be checked
    ofm_top i_dut (
        .ref_clk         (ref_clk),
        .rst             (rst),
        .clk_en          (clk_en),
        .addr            (addr),
        .wdata           (wdata),
        .wr              (wr),
        .rd              (rd),
        .low_speed_osc   (low_speed_osc),
        .crystal_osc_ref (crystal_osc_ref),
        .i2s_ws          (i2s_ws),
        .coarse_in       (coarse_in),
        .trim_in         (trim_in),
        .rdata           (rdata),
        .fine_trim_out   (fine_trim_out),
        .irq             (irq)
    );

    // 25 MHz peripheral clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // references locked to the clock so every count is exact; periods 800, 16, 12
    always @(posedge ref_clk) begin
        ph_s <= (ph_s == 399) ? 0 : ph_s + 1;
        ph_x <= (ph_x == 7) ? 0 : ph_x + 1;
        ph_w <= (ph_w == 5) ? 0 : ph_w + 1;
        if (ph_s == 399) low_speed_osc <= ~low_speed_osc;
        if (ph_x == 7) crystal_osc_ref <= ~crystal_osc_ref;
        if (ph_w == 5) i2s_ws <= ~i2s_ws;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe is taken
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd_reg(a, v);
        check(v, exp);
    endtask

    // program source and window first, then enable, poll done, read, disable
    task automatic measure(input logic [1:0] src, input logic [7:0] sel, input logic [15:0] exp);
        logic [31:0] v;
        int          i;
        wr_reg(OFS_CTRL, {8'h00, sel, 14'h0, src});
        wr_reg(OFS_CTRL, {8'h80, sel, 14'h0, src});
        rd_chk(OFS_CTRL, {8'h80, sel, 14'h0, src});
        v = '0;
        for (i = 0; i < 40000 && v[DONE_BIT] !== 1'b1; i++) rd_reg(OFS_CTRL, v);
        check(v, {8'h80, sel, 14'h1, src});
        rd_chk(OFS_COUNT, {16'h0000, exp});
        wr_reg(OFS_CTRL, {8'h00, sel, 14'h0, src});
        rd_chk(OFS_CTRL, {8'h00, sel, 14'h0, src});
    endtask

    // count cycles that the fine trim spends on the neighbouring setting
    task automatic dither(input logic [7:0] sf, input logic [7:0] tr, input logic [7:0] alt, input int hits);
        int n;
        int odd;
        @(posedge ref_clk);
        trim_in <= tr;
        wr_reg(OFS_TRIM, {8'hFF, sf, 16'hFFFF});
        rd_chk(OFS_TRIM, {8'h00, sf, coarse_in, tr});
        repeat (4) @(posedge ref_clk);
        n   = 0;
        odd = 0;
        repeat (128) begin
            @(posedge ref_clk);
            #1;
            if (fine_trim_out === alt) n++;
            else if (fine_trim_out !== tr) odd++;
        end
        check(n, hits);
        check(odd, 0);
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog past the whole run of about 70000 cycles, inside the cycle budget
    initial begin
        repeat (90000) @(posedge ref_clk);
        error_cnt++;
        stop_test;
    end

    // main sequence
    initial begin
        rst             = 1'b1;
        clk_en          = 1'b1;
        addr            = '0;
        wdata           = '0;
        wr              = 1'b0;
        rd              = 1'b0;
        low_speed_osc   = 1'b0;
        crystal_osc_ref = 1'b0;
        i2s_ws          = 1'b0;
        coarse_in       = 8'hA5;
        trim_in         = 8'h3C;
        error_cnt       = 0;
        n_tests         = 0;
        ph_s            = 0;
        ph_x            = 0;
        ph_w            = 0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        // reset values, unmapped place, read-only fields
        rd_chk(OFS_CTRL, CTRL_RST);
        rd_chk(OFS_COUNT, 32'h0000_0000);
        rd_chk(OFS_IRQ_STAT, 32'h0000_0000);
        rd_chk(OFS_IRQ_MASK, 32'h0000_0000);
        rd_chk(8'hF0, 32'h0000_0000);
        rd_chk(OFS_TRIM, {16'h0000, 8'hA5, 8'h3C});
        wr_reg(OFS_COUNT, 32'hFFFF_FFFF);
        rd_chk(OFS_COUNT, 32'h0000_0000);
        // crystal reference, smallest window then eight periods
        measure(2'b01, 8'h00, 16'h0010);
        measure(2'b01, 8'h07, 16'h0080);
        // interrupt: status sticky, masked, then unmasked and cleared
        check(irq, 1'b0);
        rd_chk(OFS_IRQ_STAT, 32'h0000_0001);
        wr_reg(OFS_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(posedge ref_clk);
        check(irq, 1'b1);
        wr_reg(OFS_IRQ_STAT, 32'h0000_0001);
        repeat (2) @(posedge ref_clk);
        check(irq, 1'b0);
        rd_chk(OFS_IRQ_STAT, 32'h0000_0000);
        // a write while the clock enable is low is ignored
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr_reg(OFS_IRQ_MASK, 32'h0000_0000);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        rd_chk(OFS_IRQ_MASK, 32'h0000_0001);
        // word-select on both upper codes, slow oscillator on code zero
        measure(2'b10, 8'h02, 16'h0024);
        measure(2'b11, 8'h02, 16'h0024);
        measure(2'b00, 8'h00, 16'h0320);
        rd_chk(OFS_COUNT, 32'h0000_0320);
        // 82 slow periods run past the counter's range
        wr_reg(OFS_IRQ_STAT, 32'h0000_0003);
        measure(2'b00, 8'h51, 16'hFFFF);
        rd_chk(OFS_IRQ_STAT, 32'h0000_0003);
        // superfine: signed dither toward one setting up or down
        dither(8'h00, 8'h3C, 8'h3D, 0);
        dither(8'h01, 8'h3C, 8'h3D, 1);
        dither(8'h40, 8'h3C, 8'h3D, 64);
        dither(8'h7F, 8'h3C, 8'h3D, 127);
        dither(8'hE0, 8'h3C, 8'h3B, 32);
        dither(8'hFF, 8'h3C, 8'h3B, 1);
        dither(8'h40, 8'hFF, 8'hFF, 128);
        dither(8'hC0, 8'h00, 8'h00, 128);
        stop_test;
    end
endmodule
